//--- logic/nba_defines.svh
// offsets, field positions, reset values and timing figures of the byte nvm access block
`ifndef NBA_DEFINES_SVH
`define NBA_DEFINES_SVH

`define NBA_ADDR_W          9
`define NBA_DATA_W          8
`define NBA_MEM_BYTES       512
`define NBA_ADDR_MASK       9'h1FF

`define NBA_SEL_W           2
`define NBA_REG_ADDR_LOW    2'h0
`define NBA_REG_ADDR_HIGH   2'h1
`define NBA_REG_DATA        2'h2
`define NBA_REG_CONTROL     2'h3

`define NBA_CTL_READ_BIT    0
`define NBA_CTL_PE_BIT      1
`define NBA_CTL_MPE_BIT     2
`define NBA_CTL_RIE_BIT     3
`define NBA_CTL_MODE_LSB    4
`define NBA_CTL_MODE_MSB    5

`define NBA_DATA_RESET      8'h00
`define NBA_MODE_RESET      2'h0
`define NBA_ERASED_BYTE     8'hFF

`define NBA_MPE_CYCLES      3'h4
`define NBA_READ_STALL      3'h4
`define NBA_PROG_STALL      3'h2

`define NBA_T_ATOMIC_US     3400
`define NBA_T_SPLIT_US      1800
`define NBA_OSC_KHZ         8000
`define NBA_TICK_W          16

`endif

//--- logic/nba_pkg.sv
// types shared by the byte nvm access block
`include "nba_defines.svh"
package nba_pkg;

  typedef enum logic [1:0] {
    NBA_MODE_ATOMIC   = 2'b00,
    NBA_MODE_ERASE    = 2'b01,
    NBA_MODE_WRITE    = 2'b10,
    NBA_MODE_RESERVED = 2'b11
  } nba_mode_t;

  typedef enum logic [0:0] {
    NBA_ENG_IDLE = 1'b0,
    NBA_ENG_RUN  = 1'b1
  } nba_eng_fsm_t;

  typedef struct packed {
    nba_eng_fsm_t                fsm;
    nba_mode_t                   mode;
    nba_mode_t                   op;
    logic [`NBA_TICK_W-1:0]      cnt;
    logic [`NBA_ADDR_W-1:0]      addr;
    logic [`NBA_DATA_W-1:0]      data;
    logic                        tick_s1;
    logic                        tick_s2;
    logic                        tick_s3;
    logic                        rst_s1;
    logic                        rst_s2;
    logic                        done;
  } nba_eng_state_t;

  typedef struct packed {
    logic [`NBA_ADDR_W-1:0]      addr;
    logic [`NBA_DATA_W-1:0]      data;
    logic                        rie;
    logic [2:0]                  mpe_cnt;
    logic [2:0]                  stall_cnt;
    logic [`NBA_DATA_W-1:0]      rdata;
  } nba_ctrl_state_t;

endpackage : nba_pkg

//--- logic/nba_eng_if.sv
// link between the register side and the programming timer
`timescale 1ns/1ps
`include "nba_defines.svh"
interface nba_eng_if;
  logic                        start;
  logic [`NBA_ADDR_W-1:0]      start_addr;
  logic [`NBA_DATA_W-1:0]      start_data;
  logic                        mode_wr;
  nba_pkg::nba_mode_t          mode_wdata;
  nba_pkg::nba_mode_t          mode;
  logic                        busy;
  logic                        done;
  nba_pkg::nba_mode_t          done_op;
  logic [`NBA_ADDR_W-1:0]      done_addr;
  logic [`NBA_DATA_W-1:0]      done_data;

  modport ctrl (output start, start_addr, start_data, mode_wr, mode_wdata,
                input  mode, busy, done, done_op, done_addr, done_data);
  modport eng  (input  start, start_addr, start_data, mode_wr, mode_wdata,
                output mode, busy, done, done_op, done_addr, done_data);
endinterface : nba_eng_if

//--- logic/nba_prog_timer.sv
// programming engine timed by the trimmed oscillator, survives system reset
`timescale 1ns/1ps
`include "nba_defines.svh"
module nba_prog_timer #(
  parameter int ATOMIC_TICKS = 27200,
  parameter int SPLIT_TICKS  = 14400
) (
  input  wire logic      clk,
  input  wire logic      por,
  input  wire logic      sys_reset,
  input  wire logic      osc_tick,
  nba_eng_if.eng         eng
);

  nba_pkg::nba_eng_state_t st_r;
  nba_pkg::nba_eng_state_t st_nxt;
  logic                    tick_edge;

  // the second and third stages feed the edge detect
  assign tick_edge = st_r.tick_s2 & ~st_r.tick_s3;

  always_comb begin
    st_nxt         = st_r;
    st_nxt.tick_s1 = osc_tick;
    st_nxt.tick_s2 = st_r.tick_s1;
    st_nxt.tick_s3 = st_r.tick_s2;
    st_nxt.rst_s1  = sys_reset;
    st_nxt.rst_s2  = st_r.rst_s1;
    st_nxt.done    = 1'b0;
    case (st_r.fsm)
      nba_pkg::NBA_ENG_IDLE: begin
        // the commit cycle still counts as busy, so it keeps the mode
        if (st_r.rst_s2 && !st_r.done) begin
          st_nxt.mode = nba_pkg::nba_mode_t'(`NBA_MODE_RESET);
        end
        // a write after release beats the lagging synchronised reset
        if (eng.mode_wr && !st_r.done) begin
          st_nxt.mode = eng.mode_wdata;
        end
        // start is only raised for a defined mode
        if (eng.start) begin
          st_nxt.fsm  = nba_pkg::NBA_ENG_RUN;
          st_nxt.op   = st_nxt.mode;
          st_nxt.addr = eng.start_addr;
          st_nxt.data = eng.start_data;
          st_nxt.cnt  = (st_nxt.mode == nba_pkg::NBA_MODE_ATOMIC) ?
                        `NBA_TICK_W'(ATOMIC_TICKS) : `NBA_TICK_W'(SPLIT_TICKS);
        end
      end
      nba_pkg::NBA_ENG_RUN: begin
        // system reset does not abort a running operation
        if (tick_edge) begin
          st_nxt.cnt = st_r.cnt - `NBA_TICK_W'(1);
          if (st_r.cnt <= `NBA_TICK_W'(1)) begin
            st_nxt.fsm  = nba_pkg::NBA_ENG_IDLE;
            st_nxt.done = 1'b1;
          end
        end
      end
      default: st_nxt.fsm = nba_pkg::NBA_ENG_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign eng.mode      = st_r.mode;
  // busy spans the commit cycle so no read sees the old byte
  assign eng.busy      = (st_r.fsm == nba_pkg::NBA_ENG_RUN) || st_r.done;
  assign eng.done      = st_r.done;
  assign eng.done_op   = st_r.op;
  assign eng.done_addr = st_r.addr;
  assign eng.done_data = st_r.data;

endmodule : nba_prog_timer

//--- logic/nba_access_ctrl.sv
// register side and byte array of the on-chip data nvm
`timescale 1ns/1ps
`include "nba_defines.svh"

// Overview of operation
// - nine-bit byte address over two registers; unused high bits read zero
// - eight-bit data register, resets to zero, carries write and read bytes
// - control bits seven and six are read-only zero
// - mode 00 atomic 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms
// - mode field writes ignored while program enable is set
// - reset clears mode field unless programming is in progress
// - ready interrupt held as a level whenever enabled and not busy
// - master enable clears itself four cycles after software sets it
// - program enable starts operation only while master enable still set
// - program enable stays set during operation, clears when time elapses
// - cpu stalled two cycles after program enable is set
// - read strobe fetches byte at once and stalls cpu four cycles
// - no read and no address change while programming
// - no other array operation while an erase or write runs
// - programming time counted on trimmed oscillator ticks
// - reset during programming lets the operation complete
module nba_access_ctrl #(
  parameter int ATOMIC_TICKS = `NBA_T_ATOMIC_US * `NBA_OSC_KHZ / 1000,
  parameter int SPLIT_TICKS  = `NBA_T_SPLIT_US * `NBA_OSC_KHZ / 1000
) (
  input  wire logic                   CORE_CLK,
  input  wire logic                   RESET,
  input  wire logic                   POWER_ON_RESET,
  input  wire logic                   OSC_TICK,
  input  wire logic [`NBA_SEL_W-1:0]  IO_SEL,
  input  wire logic                   IO_WR,
  input  wire logic                   IO_RD,
  input  wire logic [`NBA_DATA_W-1:0] IO_WDATA,
  output logic      [`NBA_DATA_W-1:0] IO_RDATA,
  input  wire logic                   GLOBAL_IRQ_EN,
  output logic                        IRQ_READY,
  output logic                        CPU_STALL
);

  nba_pkg::nba_ctrl_state_t st_r;
  nba_pkg::nba_ctrl_state_t st_nxt;
  logic [`NBA_DATA_W-1:0]   mem_r [`NBA_MEM_BYTES];

  nba_eng_if eng_if ();

  logic                     mpe_active;
  logic                     wr_addr_low;
  logic                     wr_addr_high;
  logic                     wr_data;
  logic                     wr_ctrl;
  logic                     prog_req;
  logic                     read_req;
  logic                     mode_ok;
  nba_pkg::nba_mode_t       mode_eff;
  logic [`NBA_ADDR_W-1:0]   mem_index;

  // register select decode shared by the write paths
  function automatic logic sel_hit(input logic [`NBA_SEL_W-1:0] sel,
                                   input logic [`NBA_SEL_W-1:0] reg_idx);
    sel_hit = (sel == reg_idx);
  endfunction : sel_hit

  // readback mux; program enable mirrors engine busy
  function automatic logic [`NBA_DATA_W-1:0] reg_read(
    input logic [`NBA_SEL_W-1:0]    sel,
    input nba_pkg::nba_ctrl_state_t st,
    input nba_pkg::nba_mode_t       mode,
    input logic                     busy,
    input logic                     mpe
  );
    logic [`NBA_DATA_W-1:0] v;
    v = 8'h00;
    case (sel)
      `NBA_REG_ADDR_LOW: begin
        v = st.addr[7:0];
      end
      `NBA_REG_ADDR_HIGH: begin
        v = {7'h00, st.addr[8]};
      end
      `NBA_REG_DATA: begin
        v = st.data;
      end
      `NBA_REG_CONTROL: begin
        v[`NBA_CTL_MODE_MSB:`NBA_CTL_MODE_LSB] = mode;
        v[`NBA_CTL_RIE_BIT]  = st.rie;
        v[`NBA_CTL_MPE_BIT]  = mpe;
        v[`NBA_CTL_PE_BIT]   = busy;
        v[`NBA_CTL_READ_BIT] = 1'b0;
        v[7:6]               = 2'b00;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    reg_read = v;
  endfunction : reg_read

  assign mpe_active   = (st_r.mpe_cnt != 3'h0);
  assign wr_addr_low  = IO_WR && sel_hit(IO_SEL, `NBA_REG_ADDR_LOW);
  assign wr_addr_high = IO_WR && sel_hit(IO_SEL, `NBA_REG_ADDR_HIGH);
  assign wr_data      = IO_WR && sel_hit(IO_SEL, `NBA_REG_DATA);
  assign wr_ctrl      = IO_WR && sel_hit(IO_SEL, `NBA_REG_CONTROL);

  // mode that a start in this cycle would use; ignored writes while busy
  assign mode_eff = (wr_ctrl && !eng_if.busy) ?
                    nba_pkg::nba_mode_t'(IO_WDATA[`NBA_CTL_MODE_MSB:`NBA_CTL_MODE_LSB]) :
                    eng_if.mode;

  assign mode_ok  = (mode_eff != nba_pkg::NBA_MODE_RESERVED);

  // master enable must already be active before this write
  assign prog_req = wr_ctrl && IO_WDATA[`NBA_CTL_PE_BIT] && mpe_active &&
                    !eng_if.busy && mode_ok;

  // read refused while the engine is busy
  assign read_req = wr_ctrl && IO_WDATA[`NBA_CTL_READ_BIT] && !eng_if.busy;

  assign mem_index = st_r.addr & `NBA_ADDR_MASK;

  always_comb begin
    st_nxt = st_r;

    if (st_r.mpe_cnt != 3'h0) begin
      st_nxt.mpe_cnt = st_r.mpe_cnt - 3'h1;
    end
    if (st_r.stall_cnt != 3'h0) begin
      st_nxt.stall_cnt = st_r.stall_cnt - 3'h1;
    end

    // address frozen during programming
    if (wr_addr_low && !eng_if.busy) begin
      st_nxt.addr[7:0] = IO_WDATA;
    end
    if (wr_addr_high && !eng_if.busy) begin
      st_nxt.addr[8] = IO_WDATA[0];
    end

    if (wr_data) begin
      st_nxt.data = IO_WDATA;
    end

    if (wr_ctrl) begin
      st_nxt.rie = IO_WDATA[`NBA_CTL_RIE_BIT];
      if (IO_WDATA[`NBA_CTL_MPE_BIT]) begin
        st_nxt.mpe_cnt = `NBA_MPE_CYCLES;
      end else begin
        st_nxt.mpe_cnt = 3'h0;
      end
    end

    if (prog_req) begin
      st_nxt.stall_cnt = `NBA_PROG_STALL;
    end

    // read wins the stall length if both strobes arrive together
    if (read_req) begin
      st_nxt.data      = mem_r[mem_index];
      st_nxt.stall_cnt = `NBA_READ_STALL;
    end

    if (IO_RD) begin
      st_nxt.rdata = reg_read(IO_SEL, st_r, eng_if.mode, eng_if.busy, mpe_active);
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // commit happens at the end of the timed window, not at the start
  always_ff @(posedge CORE_CLK) begin
    if (eng_if.done) begin
      case (eng_if.done_op)
        nba_pkg::NBA_MODE_ATOMIC: begin
          mem_r[eng_if.done_addr & `NBA_ADDR_MASK] <= eng_if.done_data;
        end
        nba_pkg::NBA_MODE_ERASE: begin
          mem_r[eng_if.done_addr & `NBA_ADDR_MASK] <= `NBA_ERASED_BYTE;
        end
        nba_pkg::NBA_MODE_WRITE: begin
          // a write can only clear bits; an unerased byte ends up mixed
          mem_r[eng_if.done_addr & `NBA_ADDR_MASK] <=
            mem_r[eng_if.done_addr & `NBA_ADDR_MASK] & eng_if.done_data;
        end
        default: begin
          mem_r[eng_if.done_addr & `NBA_ADDR_MASK] <=
            mem_r[eng_if.done_addr & `NBA_ADDR_MASK];
        end
      endcase
    end
  end

  assign eng_if.start      = prog_req;
  assign eng_if.start_addr = st_r.addr;
  assign eng_if.start_data = st_r.data;
  assign eng_if.mode_wr    = wr_ctrl;
  assign eng_if.mode_wdata =
    nba_pkg::nba_mode_t'(IO_WDATA[`NBA_CTL_MODE_MSB:`NBA_CTL_MODE_LSB]);

  // engine runs on power-on reset only, so system reset cannot abort it
  nba_prog_timer #(
    .ATOMIC_TICKS (ATOMIC_TICKS),
    .SPLIT_TICKS  (SPLIT_TICKS)
  ) u_timer (
    .clk       (CORE_CLK),
    .por       (POWER_ON_RESET),
    .sys_reset (RESET),
    .osc_tick  (OSC_TICK),
    .eng       (eng_if.eng)
  );

  assign IRQ_READY = st_r.rie && GLOBAL_IRQ_EN && !eng_if.busy;
  assign CPU_STALL = (st_r.stall_cnt != 3'h0);
  assign IO_RDATA  = st_r.rdata;

endmodule : nba_access_ctrl

//--- tb/nba_access_monitor.sv
// port assertions for the byte nvm access block
`timescale 1ns/1ps
module nba_access_monitor #(
  parameter int ATOMIC_TICKS = 27200,
  parameter int SPLIT_TICKS  = 14400
) (
  input wire logic       CORE_CLK,
  input wire logic       RESET,
  input wire logic       POWER_ON_RESET,
  input wire logic       OSC_TICK,
  input wire logic [1:0] IO_SEL,
  input wire logic       IO_WR,
  input wire logic       IO_RD,
  input wire logic [7:0] IO_WDATA,
  input wire logic [7:0] IO_RDATA,
  input wire logic       GLOBAL_IRQ_EN,
  input wire logic       IRQ_READY,
  input wire logic       CPU_STALL
);
  logic [2:0]  win_r;
  logic [15:0] since_r;
  logic        ctl_wr;
  logic        start;
  logic        start_q;
  logic        idle;
  assign ctl_wr = IO_WR && IO_SEL == 2'h3;
  assign idle   = since_r > 16'(ATOMIC_TICKS * 16 + 32);
  assign start  = ctl_wr && IO_WDATA[1] && !IO_WDATA[0] && win_r != 3'h0 && IO_WDATA[5:4] != 2'h3;
  // any write with master enable set reloads the window
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      win_r   <= 3'h0;
      start_q <= 1'b0;
    end else begin
      start_q <= start;
      if (ctl_wr) win_r <= IO_WDATA[2] ? 3'h4 : 3'h0;
      else if (win_r != 3'h0) win_r <= win_r - 3'h1;
    end
  end
  // engine outlives system reset, so only power-on clears this
  always_ff @(posedge CORE_CLK or posedge POWER_ON_RESET) begin
    if (POWER_ON_RESET) since_r <= 16'hFFFF;
    // a refused start raises no stall, so it leaves the count alone
    else if (start_q && CPU_STALL) since_r <= 16'h0001;
    else if (since_r != 16'hFFFF) since_r <= since_r + 16'h0001;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  AST_READ_STALL: assert property (ctl_wr && IO_WDATA[0] && idle |=> CPU_STALL [*4] ##1 !CPU_STALL)
    else $error("read stall length wrong");
  AST_PROG_STALL: assert property (start && idle |=> CPU_STALL [*2] ##1 !CPU_STALL)
    else $error("program stall length wrong");
  AST_NO_START: assert property (ctl_wr && IO_WDATA[1:0] == 2'h2 && win_r == 3'h0 |=> !CPU_STALL [*3])
    else $error("program started without master enable");
  AST_MPE_EXPIRE: assert property (ctl_wr && IO_WDATA[2:0] == 3'h4 ##1 !IO_WR [*4] ##1
    ctl_wr && IO_WDATA[2:0] == 3'h2 |=> !CPU_STALL [*3])
    else $error("master enable outlived four cycles");
  AST_RESERVED: assert property (ctl_wr && IO_WDATA[1:0] == 2'h2 && IO_WDATA[5:4] == 2'h3 |=> !CPU_STALL [*3])
    else $error("reserved mode started an operation");
  AST_BUSY_NO_IRQ: assert property (start |=> !IRQ_READY [*4])
    else $error("ready request while programming");
  AST_READ_BUSY: assert property (ctl_wr && IO_WDATA[0] && since_r < 16'(SPLIT_TICKS * 4) |=> !CPU_STALL)
    else $error("read accepted while programming");
  AST_PROG_BUSY: assert property (start && since_r < 16'(SPLIT_TICKS * 4) |=> !CPU_STALL [*2])
    else $error("second operation accepted while programming");
  AST_IRQ_GATE: assert property (IRQ_READY |-> GLOBAL_IRQ_EN)
    else $error("ready request without global enable");
  AST_CTL_RSVD: assert property (IO_RD && IO_SEL == 2'h3 |=> IO_RDATA[7:6] == 2'h0)
    else $error("control bits seven and six not zero");
  AST_ADDR_HIGH: assert property (IO_RD && IO_SEL == 2'h1 |=> IO_RDATA[7:1] == 7'h00)
    else $error("unused address bits not zero");
endmodule : nba_access_monitor
bind nba_access_ctrl nba_access_monitor #(.ATOMIC_TICKS(ATOMIC_TICKS), .SPLIT_TICKS(SPLIT_TICKS))
  mon_u (.CORE_CLK(CORE_CLK), .RESET(RESET), .POWER_ON_RESET(POWER_ON_RESET), .OSC_TICK(OSC_TICK),
  .IO_SEL(IO_SEL), .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA),
  .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .IRQ_READY(IRQ_READY), .CPU_STALL(CPU_STALL));

//--- tb/nba_cpu_model.sv
// cpu core model issuing io register accesses
`timescale 1ns/1ps
module nba_cpu_model (
  input  wire logic       clk,
  output logic [1:0]      io_sel,
  output logic            io_wr,
  output logic            io_rd,
  output logic [7:0]      io_wdata,
  input  wire logic [7:0] io_rdata,
  input  wire logic       cpu_stall
);
  initial begin
    io_sel = 2'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // a halted core issues nothing until the stall lifts
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    @(negedge clk);
    while (cpu_stall) @(negedge clk);
    io_sel = sel;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
    io_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [1:0] sel, output logic [7:0] d);
    @(negedge clk);
    while (cpu_stall) @(negedge clk);
    io_sel = sel;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    d = io_rdata;
  endtask : rd
endmodule : nba_cpu_model

//--- tb/tb_byte_eeprom_access_control.sv
// self-checking bench for the byte nvm access block
`timescale 1ns/1ps
module tb_byte_eeprom_access_control;
  logic       CORE_CLK, RESET, POWER_ON_RESET, OSC_TICK, GLOBAL_IRQ_EN;
  logic       IO_WR, IO_RD, IRQ_READY, CPU_STALL;
  logic [1:0] IO_SEL;
  logic [7:0] IO_WDATA, IO_RDATA, v;
  logic [1:0] md[3] = '{2'h0, 2'h1, 2'h2};
  logic [7:0] dv[3] = '{8'h3C, 8'h00, 8'h5A};
  logic [7:0] ex[3] = '{8'h3C, 8'hFF, 8'h5A};
  int         num_errors = 0;
  int         n_compared = 0;
  nba_access_ctrl #(.ATOMIC_TICKS(5), .SPLIT_TICKS(3)) dut_u (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .POWER_ON_RESET(POWER_ON_RESET), .OSC_TICK(OSC_TICK), .IO_SEL(IO_SEL), .IO_WR(IO_WR),
    .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
    .IRQ_READY(IRQ_READY), .CPU_STALL(CPU_STALL));
  nba_cpu_model cpu_u (.clk(CORE_CLK), .io_sel(IO_SEL), .io_wr(IO_WR), .io_rd(IO_RD),
    .io_wdata(IO_WDATA), .io_rdata(IO_RDATA), .cpu_stall(CPU_STALL));
  initial begin
    CORE_CLK = 1'b0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end
  // slow trimmed oscillator, phase unrelated to the core clock
  initial begin
    OSC_TICK = 1'b0;
    #3;
    forever #20 OSC_TICK = ~OSC_TICK;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rdchk(input logic [1:0] sel, input logic [7:0] exp, input string what);
    cpu_u.rd(sel, v);
    chk(what, exp, v);
  endtask : rdchk
  task automatic arm(input logic [1:0] mode);
    cpu_u.wr(2'h3, {2'h0, mode, 4'hC});
    cpu_u.wr(2'h3, {2'h0, mode, 4'hE});
  endtask : arm
  task automatic wait_idle;
    for (int i = 0; i < 100; i++) begin
      cpu_u.rd(2'h3, v);
      if (v[1] === 1'b0) return;
    end
    chk("busy flag", 8'h00, v);
  endtask : wait_idle
  task automatic rdbyte(input logic [7:0] exp);
    cpu_u.wr(2'h3, 8'h09);
    rdchk(2'h2, exp, "stored byte");
  endtask : rdbyte
  task automatic pulse_reset;
    RESET = 1'b1;
    repeat (3) @(negedge CORE_CLK);
    RESET = 1'b0;
  endtask : pulse_reset
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (5000) @(posedge CORE_CLK);
    chk("watchdog", 8'h00, 8'h01);
    summarize;
  end
  initial begin
    RESET = 1'b1;
    POWER_ON_RESET = 1'b1;
    GLOBAL_IRQ_EN = 1'b1;
    repeat (4) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    RESET = 1'b0;
    POWER_ON_RESET = 1'b0;
    rdchk(2'h2, 8'h00, "data reset");
    rdchk(2'h3, 8'h00, "control reset");
    cpu_u.wr(2'h1, 8'hFF);
    rdchk(2'h1, 8'h01, "address high");
    cpu_u.wr(2'h0, 8'hA5);
    cpu_u.wr(2'h3, 8'h09);
    chk("read stall", 8'h01, {7'h00, CPU_STALL});
    rdchk(2'h3, 8'h08, "control after read");
    chk("ready level", 8'h01, {7'h00, IRQ_READY});
    GLOBAL_IRQ_EN = 1'b0;
    @(negedge CORE_CLK);
    chk("ready gated", 8'h00, {7'h00, IRQ_READY});
    GLOBAL_IRQ_EN = 1'b1;
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      cpu_u.wr(2'h2, dv[i]);
      arm(md[i]);
      chk("program stall", 8'h01, {7'h00, CPU_STALL});
      arm(2'h0);
      cpu_u.wr(2'h0, 8'h00);
      cpu_u.wr(2'h3, 8'h19);
      rdchk(2'h3, {2'h0, md[i], 4'hA}, "busy control");
      chk("ready while busy", 8'h00, {7'h00, IRQ_READY});
      wait_idle;
      rdbyte(ex[i]);
    end
    $display("test modes done");
    cpu_u.wr(2'h3, 8'h0C);
    repeat (3) @(negedge CORE_CLK);
    cpu_u.wr(2'h3, 8'h0A);
    chk("late start stall", 8'h00, {7'h00, CPU_STALL});
    rdchk(2'h3, 8'h08, "expired enable");
    cpu_u.wr(2'h3, 8'h3C);
    cpu_u.wr(2'h3, 8'h3E);
    chk("reserved stall", 8'h00, {7'h00, CPU_STALL});
    cpu_u.wr(2'h3, 8'h38);
    rdchk(2'h3, 8'h38, "reserved mode");
    rdbyte(8'h5A);
    $display("test refusals done");
    arm(2'h1);
    pulse_reset;
    rdchk(2'h3, 8'h12, "control after reset");
    wait_idle;
    pulse_reset;
    rdchk(2'h3, 8'h00, "mode after idle reset");
    cpu_u.wr(2'h1, 8'h01);
    cpu_u.wr(2'h0, 8'hA5);
    rdbyte(8'hFF);
    $display("test reset done");
    summarize;
  end
endmodule : tb_byte_eeprom_access_control
